// [logic/aarm_seq_ptr.sv]
// Purpose: Read-sequence pointer package and per-port step counter for alternate access read-back
// Assumes: One clock, synchronous active-high reset
// Notes:   The package shares port addresses and sequence lengths with the main module
//==============================================================================
// Shared constants
//==============================================================================
package aarm_pkg;
	localparam logic [15:0] AARM_PORT_DMA_LO_CMD = 16'h0008;
	localparam logic [15:0] AARM_PORT_DMA_HI_CMD = 16'h00d0;
	localparam logic [15:0] AARM_PORT_PIC        = 16'h0020;
	localparam logic [15:0] AARM_PORT_TMR0       = 16'h0040;
	localparam logic [15:0] AARM_PORT_TMR1       = 16'h0041;
	localparam logic [15:0] AARM_PORT_TMR2       = 16'h0042;
	localparam logic [15:0] AARM_PORT_RTC_INDEX  = 16'h0070;
	localparam logic [15:0] AARM_PORT_DMA_LO_LAST = 16'h0007;
	localparam logic [15:0] AARM_PORT_DMA_HI_FIRST = 16'h00c4;
	localparam logic [15:0] AARM_PORT_DMA_HI_LAST = 16'h00ce;
	localparam logic [15:0] AARM_PORT_DMA_HI_STEP = 16'h0002;
	localparam int AARM_DMA_PORTS     = 14;
	localparam int AARM_DMA_LO_PORTS  = 8;
	localparam int AARM_LEN_DMA_BASE  = 2;
	localparam int AARM_LEN_DMA_STAT  = 6;
	localparam int AARM_LEN_PIC       = 12;
	localparam int AARM_LEN_TMR       = 7;
	localparam logic [7:0] AARM_DMA_CMD_MASK = 8'hd4;
	localparam logic [7:0] AARM_RD_DATA_RST  = 8'h00;
endpackage

`timescale 1ns/1ns

//==============================================================================
// Step counter: cleared on mode entry, advances per read, wraps after LEN
//==============================================================================
module aarm_seq_ptr #(
	parameter int LEN = 2
) (
	input  wire logic                   clk,
	input  wire logic                   rst,
	input  wire logic                   clear,
	input  wire logic                   step,
	output logic [$clog2(LEN)-1:0]      ptr
);
	localparam logic [$clog2(LEN)-1:0] LAST = ($clog2(LEN))'(LEN - 1);

	// A one-entry sequence would give a zero-width pointer
	generate
		if (LEN < 2) begin : g_len_check
			$error("aarm_seq_ptr: LEN must be at least 2");
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (rst || clear)
			ptr <= '0; // [RL14]
		else if (step)
			ptr <= (ptr == LAST) ? '0 : ptr + 1'b1; // [RL2] [RL14]
	end
endmodule // aarm_seq_ptr

// [logic/aarm_readback_mux.sv]
// Purpose: Alternate access read-back of shadowed write-only legacy registers
// Assumes: IO_RD and IO_ADDR come from logic on MCLK; shadow values are held elsewhere
// Notes:   RD_CLAIM marks a read answered here; when low the normal read path answers
//
// Summary of operation
// RL1: In alternate access mode, reads return stored values of write-only registers.
// RL2: Multi-register ports pick the register by read ordinal, one step per read.
// RL3: DMA channel 0-3 base address/count ports: two reads, low then high byte.
// RL4: DMA channel 5-7 base address/count ports: two reads, low then high byte.
// RL5: Port 08h: six reads, command, request, modes 0-3 with channel in bits 1:0.
// RL6: Port D0h: six reads, command, request, modes 4-7 with 00..11 in bits 1:0.
// RL7: Port 20h: twelve reads, master init/operation words, then slave ones.
// RL8: Port 40h: seven reads, timer 0 status, then base counts of timers 0-2.
// RL9: Ports 41h and 42h: one read each, timer status bits 5:0.
// RL10: Port 70h: one read, NMI enable in bit 7, RTC index in bits 6:0.
// RL11: Software reads each interrupt mask word before enabling the mode.
// RL12: DMA command read-backs force bits 5, 3, 1 and 0 to zero.
// RL13: Mode exists to save write-only registers around a power-down.
// RL14: Pointers clear on mode entry and wrap after the last access.
// RL15: Outside the mode, reads behave normally and pointers hold still.
`timescale 1ns/1ns

module aarm_readback_mux
	import aarm_pkg::*;
(
	input  wire logic         MCLK,
	input  wire logic         RESET,
	input  wire logic         ALT_MODE,
	input  wire logic         IO_RD,
	input  wire logic [15:0]  IO_ADDR,
	input  wire logic [111:0] DMA_BASE_ADDR,
	input  wire logic [111:0] DMA_BASE_COUNT,
	input  wire logic [7:0]   DMA_LO_CMD,
	input  wire logic [7:0]   DMA_LO_REQ,
	input  wire logic [7:0]   DMA_HI_CMD,
	input  wire logic [7:0]   DMA_HI_REQ,
	input  wire logic [31:0]  DMA_LO_MODE,
	input  wire logic [31:0]  DMA_HI_MODE,
	input  wire logic [15:0]  PIC_INIT_WORD_TWO,
	input  wire logic [15:0]  PIC_INIT_WORD_THREE,
	input  wire logic [15:0]  PIC_INIT_WORD_FOUR,
	input  wire logic [15:0]  PIC_INTERRUPT_MASK_WORD,
	input  wire logic [15:0]  PIC_OPERATION_WORD_TWO,
	input  wire logic [15:0]  PIC_OPERATION_WORD_THREE,
	input  wire logic [17:0]  TMR_STATUS,
	input  wire logic [47:0]  TMR_BASE_COUNT,
	input  wire logic         NMI_ENABLE,
	input  wire logic [6:0]   RTC_INDEX,
	output logic              RD_CLAIM,
	output logic [7:0]        RD_DATA
);
	//==========================================================================
	// Mode entry detection
	//==========================================================================
	logic alt_q;
	logic entry;
	logic rd_alt;

	always_ff @(posedge MCLK) begin
		if (RESET)
			alt_q <= 1'b0;
		else
			alt_q <= ALT_MODE;
	end

	assign entry  = ALT_MODE & ~alt_q;
	// Pointers move only on reads taken in the mode
	assign rd_alt = IO_RD & ALT_MODE; // [RL15]

	//==========================================================================
	// Two-read DMA base ports: 00h-07h then C4h-CEh
	//==========================================================================
	logic [AARM_DMA_PORTS-1:0] dma_hit;
	logic [AARM_DMA_PORTS-1:0] dma_ptr;

	genvar g;
	generate
		for (g = 0; g < AARM_DMA_PORTS; g++) begin : g_dma
			localparam logic [15:0] PORT = (g < AARM_DMA_LO_PORTS) ? 16'(g) :
				16'(AARM_PORT_DMA_HI_FIRST + AARM_PORT_DMA_HI_STEP * (g - AARM_DMA_LO_PORTS));
			assign dma_hit[g] = rd_alt && (IO_ADDR == PORT);
			aarm_seq_ptr #(.LEN(AARM_LEN_DMA_BASE)) u_ptr (
				.clk   (MCLK),
				.rst   (RESET),
				.clear (entry),
				.step  (dma_hit[g]), // [RL3] [RL4]
				.ptr   (dma_ptr[g:g])
			);
		end
	endgenerate

	//==========================================================================
	// Multi-read status ports
	//==========================================================================
	logic [2:0] lo_ptr;
	logic [2:0] hi_ptr;
	logic [3:0] pic_ptr;
	logic [2:0] tmr_ptr;

	aarm_seq_ptr #(.LEN(AARM_LEN_DMA_STAT)) u_lo_ptr (
		.clk   (MCLK),
		.rst   (RESET),
		.clear (entry),
		.step  (rd_alt && (IO_ADDR == AARM_PORT_DMA_LO_CMD)), // [RL5]
		.ptr   (lo_ptr)
	);
	aarm_seq_ptr #(.LEN(AARM_LEN_DMA_STAT)) u_hi_ptr (
		.clk   (MCLK),
		.rst   (RESET),
		.clear (entry),
		.step  (rd_alt && (IO_ADDR == AARM_PORT_DMA_HI_CMD)), // [RL6]
		.ptr   (hi_ptr)
	);
	aarm_seq_ptr #(.LEN(AARM_LEN_PIC)) u_pic_ptr (
		.clk   (MCLK),
		.rst   (RESET),
		.clear (entry),
		.step  (rd_alt && (IO_ADDR == AARM_PORT_PIC)), // [RL7]
		.ptr   (pic_ptr)
	);
	aarm_seq_ptr #(.LEN(AARM_LEN_TMR)) u_tmr_ptr (
		.clk   (MCLK),
		.rst   (RESET),
		.clear (entry),
		.step  (rd_alt && (IO_ADDR == AARM_PORT_TMR0)), // [RL8]
		.ptr   (tmr_ptr)
	);

	//==========================================================================
	// Read-back selection
	//==========================================================================
	function automatic logic [7:0] dma_stat(
		input logic [2:0]  ptr,
		input logic [7:0]  cmd,
		input logic [7:0]  req,
		input logic [31:0] mode
	);
		logic [7:0] m;
		// Steps 2..5 map to channel bytes 0..3
		m = mode[8*(2'(ptr - 3'h2)) +: 8];
		case (ptr)
			3'h0:    dma_stat = cmd & AARM_DMA_CMD_MASK; // [RL12]
			3'h1:    dma_stat = req;
			// Channel number replaces the mode's low bits
			default: dma_stat = {m[7:2], 2'(ptr - 3'h2)}; // [RL5] [RL6]
		endcase
	endfunction

	// Reads of the interrupt mask word before the mode are software's duty;
	// here the shadow is simply returned in its place in the sequence. [RL11]
	function automatic logic [7:0] pic_word(input logic [3:0] ptr);
		logic       slave;
		logic [2:0] idx;
		slave = (ptr > 4'h5);
		idx   = slave ? 3'(ptr - 4'h6) : ptr[2:0];
		case (idx)
			3'h0:    pic_word = PIC_INIT_WORD_TWO[8*slave +: 8];
			3'h1:    pic_word = PIC_INIT_WORD_THREE[8*slave +: 8];
			3'h2:    pic_word = PIC_INIT_WORD_FOUR[8*slave +: 8];
			3'h3:    pic_word = PIC_INTERRUPT_MASK_WORD[8*slave +: 8];
			3'h4:    pic_word = PIC_OPERATION_WORD_TWO[8*slave +: 8];
			default: pic_word = PIC_OPERATION_WORD_THREE[8*slave +: 8];
		endcase
	endfunction

	logic       next_claim;
	logic [7:0] next_data;
	logic [2:0] dch;
	logic [3:0] didx;
	logic [15:0] dword;
	logic [2:0] tsel;

	always_comb begin
		next_claim = 1'b0;
		next_data  = AARM_RD_DATA_RST;
		dch        = 3'h0;
		didx       = 4'h0;
		dword      = 16'h0000;
		tsel       = 3'(tmr_ptr - 3'h1) >> 1;
		if (IO_ADDR <= AARM_PORT_DMA_LO_LAST) begin
			dch  = {1'b0, IO_ADDR[2:1]};
			didx = {1'b0, IO_ADDR[2:0]};
			dword = IO_ADDR[0] ? DMA_BASE_COUNT[16*dch +: 16] : DMA_BASE_ADDR[16*dch +: 16];
			next_data  = dma_ptr[didx] ? dword[15:8] : dword[7:0]; // [RL3]
			next_claim = 1'b1;
		end else if (IO_ADDR >= AARM_PORT_DMA_HI_FIRST && IO_ADDR <= AARM_PORT_DMA_HI_LAST &&
			!IO_ADDR[0]) begin
			dch  = 3'({1'b0, IO_ADDR[3:2]} + 3'h3);
			didx = 4'(4'(AARM_DMA_LO_PORTS) + {1'b0, IO_ADDR[3:1]} - 4'h2);
			dword = IO_ADDR[1] ? DMA_BASE_COUNT[16*dch +: 16] : DMA_BASE_ADDR[16*dch +: 16];
			next_data  = dma_ptr[didx] ? dword[15:8] : dword[7:0]; // [RL4]
			next_claim = 1'b1;
		end else begin
			next_claim = 1'b1;
			case (IO_ADDR)
				AARM_PORT_DMA_LO_CMD: next_data = dma_stat(lo_ptr, DMA_LO_CMD, DMA_LO_REQ, DMA_LO_MODE);
				AARM_PORT_DMA_HI_CMD: next_data = dma_stat(hi_ptr, DMA_HI_CMD, DMA_HI_REQ, DMA_HI_MODE);
				AARM_PORT_PIC:        next_data = pic_word(pic_ptr); // [RL7]
				AARM_PORT_TMR0: begin
					if (tmr_ptr == 3'h0)
						next_data = {2'b00, TMR_STATUS[5:0]}; // [RL8]
					else begin
						dword     = TMR_BASE_COUNT[16*tsel +: 16];
						next_data = tmr_ptr[0] ? dword[7:0] : dword[15:8]; // [RL8]
					end
				end
				AARM_PORT_TMR1:       next_data = {2'b00, TMR_STATUS[11:6]}; // [RL9]
				AARM_PORT_TMR2:       next_data = {2'b00, TMR_STATUS[17:12]}; // [RL9]
				AARM_PORT_RTC_INDEX:  next_data = {NMI_ENABLE, RTC_INDEX}; // [RL10]
				default:              next_claim = 1'b0;
			endcase
		end
	end

	//==========================================================================
	// Answer register: one cycle after the read strobe
	//==========================================================================
	// Claim only in the mode; otherwise the normal decode owns the port
	always_ff @(posedge MCLK) begin
		if (RESET) begin
			RD_CLAIM <= 1'b0;
			RD_DATA  <= AARM_RD_DATA_RST;
		end else begin
			RD_CLAIM <= rd_alt & next_claim; // [RL1] [RL13] [RL15]
			if (rd_alt && next_claim)
				RD_DATA <= next_data; // [RL1] [RL2]
		end
	end
endmodule // aarm_readback_mux

// [verif/aarm_readback_mux_chk.sv]
// Purpose: Port-level checks of the alternate access read-back mux
// Assumes: One clock, synchronous active-high reset, shadow inputs settled
// Notes:   Captured copies stand in for sampled history of wide inputs
`timescale 1ns/1ns

//==============================================================================
// Checker
//==============================================================================
module aarm_readback_mux_chk (
	input wire logic         MCLK,
	input wire logic         RESET,
	input wire logic         ALT_MODE,
	input wire logic         IO_RD,
	input wire logic [15:0]  IO_ADDR,
	input wire logic [111:0] DMA_BASE_ADDR,
	input wire logic [17:0]  TMR_STATUS,
	input wire logic         NMI_ENABLE,
	input wire logic [6:0]   RTC_INDEX,
	input wire logic         RD_CLAIM,
	input wire logic [7:0]   RD_DATA
);
	logic [17:0] tmr_q;
	logic [15:0] addr_q;
	logic [7:0]  rtc_q;

	default clocking @(posedge MCLK); endclocking
	default disable iff (RESET);

	// Values seen at the edge that took the read
	always_ff @(posedge MCLK) begin
		tmr_q  <= TMR_STATUS;
		addr_q <= DMA_BASE_ADDR[15:0];
		rtc_q  <= {NMI_ENABLE, RTC_INDEX};
	end

	sequence rd_at(logic [15:0] a);
		IO_RD && ALT_MODE && IO_ADDR == a;
	endsequence

	sequence ch0_pair;
		$rose(ALT_MODE) ##1 rd_at(16'h0000) ##1 rd_at(16'h0000);
	endsequence

	claim_cause_a: assert property (
		RD_CLAIM |-> $past(IO_RD) && $past(ALT_MODE)) else $error("claim without read");
	off_mode_a: assert property (
		IO_RD && !ALT_MODE |=> !RD_CLAIM) else $error("claim outside mode");
	unlisted_a: assert property (
		IO_RD && IO_ADDR[15:8] != 8'h00 |=> !RD_CLAIM) else $error("claim of unlisted port");
	data_hold_a: assert property (
		!RD_CLAIM && !$past(RESET) |-> $stable(RD_DATA)) else $error("data moved unclaimed");
	rtc_data_a: assert property (
		rd_at(16'h0070) |=> RD_CLAIM && RD_DATA == rtc_q) else $error("rtc index read-back");
	tmr_one_a: assert property (
		rd_at(16'h0041) |=> RD_DATA == {2'b00, tmr_q[11:6]}) else $error("timer 1 status");
	tmr_two_a: assert property (
		rd_at(16'h0042) |=> RD_DATA == {2'b00, tmr_q[17:12]}) else $error("timer 2 status");
	ch0_pair_a: assert property (
		ch0_pair |-> RD_DATA == addr_q[7:0] ##1 RD_DATA == addr_q[15:8])
		else $error("channel 0 byte order");
endmodule // aarm_readback_mux_chk

bind aarm_readback_mux aarm_readback_mux_chk chk_u (.MCLK, .RESET, .ALT_MODE, .IO_RD,
	.IO_ADDR, .DMA_BASE_ADDR, .TMR_STATUS, .NMI_ENABLE, .RTC_INDEX, .RD_CLAIM, .RD_DATA);

// [verif/test_aarm_readback_mux.sv]
// Purpose: Self-checking bench for the alternate access read-back mux
// Assumes: Reads are one-cycle strobes; answer comes exactly one cycle later
// Notes:   Shadow inputs hold distinct bytes so a wrong select shows
`timescale 1ns/1ns

module test_aarm_readback_mux;
	logic MCLK = 0, RESET = 1, ALT_MODE = 0, IO_RD = 0, NMI_ENABLE = 1, RD_CLAIM;
	logic [15:0]  IO_ADDR = 16'h0000;
	logic [111:0] DMA_BASE_ADDR, DMA_BASE_COUNT;
	logic [7:0]   DMA_LO_CMD = 8'hff, DMA_LO_REQ = 8'h0e, DMA_HI_CMD = 8'hbf, DMA_HI_REQ = 8'h0b;
	logic [31:0]  DMA_LO_MODE = 32'h9b77e6fd, DMA_HI_MODE = 32'h1235567b;
	logic [15:0]  P2 = 16'h8a18, P3 = 16'h0204, P4 = 16'h1d0f, PM = 16'hb3fa, PO2 = 16'h6627;
	logic [15:0]  PO3 = 16'h4b0a;
	logic [17:0]  TMR_STATUS = 18'h2b5c7;
	logic [47:0]  TMR_BASE_COUNT = 48'h615243342516;
	logic [6:0]   RTC_INDEX = 7'h4d;
	logic [7:0]   RD_DATA;
	int num_errors = 0, compares = 0;

	aarm_readback_mux dut_u (.MCLK, .RESET, .ALT_MODE, .IO_RD, .IO_ADDR, .DMA_BASE_ADDR,
		.DMA_BASE_COUNT, .DMA_LO_CMD, .DMA_LO_REQ, .DMA_HI_CMD, .DMA_HI_REQ, .DMA_LO_MODE,
		.DMA_HI_MODE, .PIC_INIT_WORD_TWO(P2), .PIC_INIT_WORD_THREE(P3), .PIC_INIT_WORD_FOUR(P4),
		.PIC_INTERRUPT_MASK_WORD(PM), .PIC_OPERATION_WORD_TWO(PO2),
		.PIC_OPERATION_WORD_THREE(PO3), .TMR_STATUS, .TMR_BASE_COUNT, .NMI_ENABLE,
		.RTC_INDEX, .RD_CLAIM, .RD_DATA);

	initial begin
		forever #20 MCLK = ~MCLK;
	end

	//==========================================================================
	// Shared tasks
	//==========================================================================
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %0t read-back %h expected %h", $time, got, exp);
		end
	endtask

	// One read, judged while the claim pulse stands; unclaimed reads keep the data byte
	task automatic rd(input logic [15:0] a, input logic claim, input logic [7:0] exp);
		logic [7:0] old;
		old = RD_DATA;
		IO_RD = 1;
		IO_ADDR = a;
		@(posedge MCLK) #1;
		chk({7'h00, RD_CLAIM}, {7'h00, claim});
		chk(RD_DATA, claim ? exp : old);
		IO_RD = 0;
		@(posedge MCLK) #1;
	endtask

	task automatic mode(input logic m);
		ALT_MODE = m;
		@(posedge MCLK) #1;
	endtask

	//==========================================================================
	// Scenarios
	//==========================================================================
	task automatic t_b2b();
		IO_RD = 1;
		IO_ADDR = 16'h0000;
		@(posedge MCLK) #1;
		chk({7'h00, RD_CLAIM}, 8'h01);
		chk(RD_DATA, DMA_BASE_ADDR[7:0]);
		@(posedge MCLK) #1 IO_RD = 0;
		chk({7'h00, RD_CLAIM}, 8'h01);
		chk(RD_DATA, DMA_BASE_ADDR[15:8]);
		@(posedge MCLK) #1;
	endtask

	task automatic t_dma();
		int s;
		for (int k = 0; k < 14; k++) begin
			s = (k < 8) ? k / 2 : 4 + (k - 8) / 2;
			for (int b = 0; b < 2; b++) begin
				rd((k < 8) ? 16'(k) : 16'(8'hc4 + 2 * (k - 8)), 1, k[0] ?
					DMA_BASE_COUNT[s*16+b*8 +: 8] : DMA_BASE_ADDR[s*16+b*8 +: 8]);
			end
		end
	endtask

	task automatic t_stat(input logic [15:0] a, input logic [7:0] c, input logic [7:0] r,
		input logic [31:0] m);
		rd(a, 1, c & ~8'h2b);
		rd(a, 1, r);
		for (int j = 0; j < 4; j++) begin
			rd(a, 1, {m[j*8+2 +: 6], 2'(j)});
		end
	endtask

	task automatic t_pic();
		logic [15:0] w [6];
		w = '{P2, P3, P4, PM, PO2, PO3};
		for (int j = 0; j < 12; j++) begin
			rd(16'h0020, 1, (j < 6) ? w[j][7:0] : w[j-6][15:8]);
		end
	endtask

	task automatic t_tmr();
		rd(16'h0040, 1, {2'b00, TMR_STATUS[5:0]});
		for (int j = 0; j < 6; j++) begin
			rd(16'h0040, 1, TMR_BASE_COUNT[j*8 +: 8]);
		end
		rd(16'h0040, 1, {2'b00, TMR_STATUS[5:0]});
		for (int j = 0; j < 2; j++) begin
			rd(16'h0041, 1, {2'b00, TMR_STATUS[11:6]});
			rd(16'h0042, 1, {2'b00, TMR_STATUS[17:12]});
			rd(16'h0070, 1, {NMI_ENABLE, RTC_INDEX});
		end
	endtask

	// Pointers are per port and cleared on entry; reads outside the mode and of an unlisted port go unclaimed
	task automatic t_ptr();
		rd(16'h0008, 1, DMA_LO_CMD & ~8'h2b);
		rd(16'h0020, 1, P2[7:0]);
		rd(16'h0008, 1, DMA_LO_REQ);
		mode(0);
		rd(16'h0008, 0, 8'h00);
		mode(1);
		rd(16'h0170, 0, 8'h00);
		rd(16'h0008, 1, DMA_LO_CMD & ~8'h2b);
		rd(16'h0020, 1, P2[7:0]);
	endtask

	task automatic results();
		$display("Comparisons %0d, mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	//==========================================================================
	// Main sequence
	//==========================================================================
	initial begin
		for (int i = 0; i < 14; i++) begin
			DMA_BASE_ADDR[i*8 +: 8] = 8'h10 + 8'(i);
			DMA_BASE_COUNT[i*8 +: 8] = 8'h80 + 8'(i);
		end
		repeat (3) @(posedge MCLK);
		#1 RESET = 0;
		chk({7'h00, RD_CLAIM}, 8'h00);
		chk(RD_DATA, 8'h00);
		// Mask words are read the normal way before the mode is entered
		rd(16'h0021, 0, 8'h00);
		rd(16'h00a1, 0, 8'h00);
		mode(1);
		t_b2b();
		t_dma();
		t_stat(16'h0008, DMA_LO_CMD, DMA_LO_REQ, DMA_LO_MODE);
		t_stat(16'h00d0, DMA_HI_CMD, DMA_HI_REQ, DMA_HI_MODE);
		t_pic();
		t_tmr();
		t_ptr();
		results();
	end
endmodule // test_aarm_readback_mux
